// ===== pkg/lvds_cfg_pkg.sv
// register map, field positions, reset values and timing of the lvds output and event configuration bank
package lvds_cfg_pkg;
    // register offsets
    localparam logic [7:0] ADDR_DRV_EN = 8'h27;
    localparam logic [7:0] ADDR_TIMING = 8'h28;
    localparam logic [7:0] ADDR_EVT_COUNT = 8'h29;
    localparam logic [7:0] ADDR_EVT_CFG = 8'h2b;
    // driver enable register fields
    localparam int DRV_SWING_BIT = 7;
    localparam int DRV_TAKEOVER_BIT = 6;
    localparam int DRV_CLK_EN_BIT = 5;
    localparam int DRV_LANE_MSB = 4;
    localparam int DRV_LANE_LSB = 0;
    localparam logic [7:0] DRV_EN_RESET = 8'h00;
    localparam logic [7:0] DRV_EN_MASK = 8'hff;
    // timing register fields
    localparam int TIM_RATE_BIT = 5;
    localparam int TIM_INVERT_BIT = 4;
    localparam int TIM_DELAY_MSB = 3;
    localparam int TIM_DELAY_LSB = 2;
    localparam logic [7:0] TIMING_RESET = 8'h28;
    localparam logic [7:0] TIMING_MASK = 8'h3c;
    // event configuration fields
    localparam int EVT_SELECT_BIT = 3;
    localparam int EVT_CDR_CLEAR_BIT = 2;
    localparam int EVT_DATA_CLEAR_BIT = 1;
    localparam logic [7:0] EVT_CFG_RESET = 8'h00;
    localparam logic [7:0] EVT_CFG_MASK = 8'h0e;
    // lane count and clock delay step
    localparam int LANES = 5;
    localparam int CLK_DELAY_STEP_PS = 80;
endpackage

// ===== logic/level_sync.sv
// two flip-flop synchroniser for a bundle of levels
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset of the receiving domain
    input wire logic clk,
    input wire logic rst_n,
    // levels in and out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule

// ===== logic/event_counter.sv
// wrapping event counter with a held clear
`timescale 1ns/1ps
module event_counter #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic clear,
    input wire logic [1:0] inc,
    // count
    output logic [WIDTH-1:0] count
);
    always_ff @(posedge clk) begin
        if (!rst_n || clear) begin
            count <= '0;
        end else begin
            count <= count + WIDTH'(inc);
        end
    end
endmodule

// ===== logic/lvds_output_and_event_config_regs.sv
// lvds output control and event counter configuration registers with the link-side driver stage
// Notes on behaviour
// - swing bit at 1 selects the enlarged lvds differential output swing
// - takeover bit 6 hands lvds driver control to the register settings
// - bit 5 enables the forwarded clock driver, reset value 0
// - bits 4:0 enable the matching data lane drivers, all reset to 0
// - rate bit 1 gives full ddr forwarded clock, 0 half rate; resets 1
// - invert bit flips forwarded clock polarity, reset value 0
// - delay field 3:2 adds 80 ps per count to clock path, resets 10
// - select bit 0 reads clock recovery counter, 1 reads data counter
// - clock recovery counter counts forwarded clock losses and lock losses
// - writing 1 to bit 2 clears the clock recovery counter
// - writing 1 to bit 1 clears the data event counter
`timescale 1ns/1ps
module lvds_output_and_event_config_regs #(
    parameter int COUNT_WIDTH = 8
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // link clock and its reset
    input wire logic link_clk,
    input wire logic link_rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    output logic [7:0] reg_rdata,
    // asynchronous status pins
    input wire logic pin_drivers_enable,
    input wire logic recovery_lock,
    input wire logic fwd_clk_present,
    // link-side data in
    input wire logic [lvds_cfg_pkg::LANES-1:0] lane_data,
    input wire logic data_error,
    // lane outputs
    output logic data_lane_zero,
    output logic data_lane_one,
    output logic data_lane_two,
    output logic data_lane_three,
    output logic data_lane_four,
    // lane driver enables
    output logic data_lane_zero_oe,
    output logic data_lane_one_oe,
    output logic data_lane_two_oe,
    output logic data_lane_three_oe,
    output logic data_lane_four_oe,
    // forwarded clock
    output logic forwarded_output_clock,
    output logic forwarded_output_clock_oe,
    // analog controls
    output logic output_differential_swing,
    output logic [1:0] fwd_clk_delay_code
);
    localparam int NL = lvds_cfg_pkg::LANES;

    logic [7:0] drv_en;
    logic [7:0] timing;
    logic [7:0] evt_cfg;
    logic [COUNT_WIDTH-1:0] cdr_count;
    logic [COUNT_WIDTH-1:0] data_count;
    logic [2:0] sys_sync;
    logic lock_q;
    logic clk_present_q;
    logic err_tog_q;
    logic lock_loss;
    logic clk_loss;
    logic data_evt;
    logic [1:0] cdr_inc;
    logic [1:0] data_inc;
    logic [7:0] next_rdata;

    // register writes
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            drv_en <= lvds_cfg_pkg::DRV_EN_RESET;
        end else if (reg_wr && reg_addr == lvds_cfg_pkg::ADDR_DRV_EN) begin
            drv_en <= reg_wdata & lvds_cfg_pkg::DRV_EN_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            timing <= lvds_cfg_pkg::TIMING_RESET;
        end else if (reg_wr && reg_addr == lvds_cfg_pkg::ADDR_TIMING) begin
            timing <= reg_wdata & lvds_cfg_pkg::TIMING_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            evt_cfg <= lvds_cfg_pkg::EVT_CFG_RESET;
        end else if (reg_wr && reg_addr == lvds_cfg_pkg::ADDR_EVT_CFG) begin
            evt_cfg <= reg_wdata & lvds_cfg_pkg::EVT_CFG_MASK;
        end
    end

    // analog controls straight from the registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            output_differential_swing <= 1'b0;
            fwd_clk_delay_code <= lvds_cfg_pkg::TIMING_RESET[lvds_cfg_pkg::TIM_DELAY_MSB:lvds_cfg_pkg::TIM_DELAY_LSB];
        end else begin
            output_differential_swing <= drv_en[lvds_cfg_pkg::DRV_SWING_BIT];
            fwd_clk_delay_code <= timing[lvds_cfg_pkg::TIM_DELAY_MSB:lvds_cfg_pkg::TIM_DELAY_LSB];
        end
    end

    // readback
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            lvds_cfg_pkg::ADDR_DRV_EN: next_rdata = drv_en;
            lvds_cfg_pkg::ADDR_TIMING: next_rdata = timing;
            lvds_cfg_pkg::ADDR_EVT_CFG: next_rdata = evt_cfg;
            lvds_cfg_pkg::ADDR_EVT_COUNT: begin
                next_rdata = evt_cfg[lvds_cfg_pkg::EVT_SELECT_BIT] ? 8'(data_count) : 8'(cdr_count);
            end
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // status pins and the data error toggle into the system domain
    logic err_tog_l;

    level_sync #(.WIDTH(3)) u_sys_sync (
        .clk(sys_clk),
        .rst_n(rst_n),
        .async_in({err_tog_l, fwd_clk_present, recovery_lock}),
        .sync_out(sys_sync)
    );

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
            clk_present_q <= 1'b0;
            err_tog_q <= 1'b0;
        end else begin
            lock_q <= sys_sync[0];
            clk_present_q <= sys_sync[1];
            err_tog_q <= sys_sync[2];
        end
    end

    assign lock_loss = lock_q && !sys_sync[0];
    assign clk_loss = clk_present_q && !sys_sync[1];
    assign data_evt = err_tog_q != sys_sync[2];
    assign cdr_inc = {1'b0, lock_loss} + {1'b0, clk_loss};
    assign data_inc = {1'b0, data_evt};

    event_counter #(.WIDTH(COUNT_WIDTH)) u_cdr_count (
        .clk(sys_clk),
        .rst_n(rst_n),
        .clear(evt_cfg[lvds_cfg_pkg::EVT_CDR_CLEAR_BIT]),
        .inc(cdr_inc),
        .count(cdr_count)
    );

    event_counter #(.WIDTH(COUNT_WIDTH)) u_data_count (
        .clk(sys_clk),
        .rst_n(rst_n),
        .clear(evt_cfg[lvds_cfg_pkg::EVT_DATA_CLEAR_BIT]),
        .inc(data_inc),
        .count(data_count)
    );

    // configuration into the link domain
    logic [NL+4:0] link_cfg;
    logic takeover_l;
    logic clk_en_l;
    logic [NL-1:0] lane_en_l;
    logic rate_l;
    logic invert_l;
    logic pin_en_l;

    level_sync #(.WIDTH(NL+5)) u_link_sync (
        .clk(link_clk),
        .rst_n(link_rst_n),
        .async_in({pin_drivers_enable,
                   timing[lvds_cfg_pkg::TIM_INVERT_BIT],
                   timing[lvds_cfg_pkg::TIM_RATE_BIT],
                   drv_en[lvds_cfg_pkg::DRV_LANE_MSB:lvds_cfg_pkg::DRV_LANE_LSB],
                   drv_en[lvds_cfg_pkg::DRV_CLK_EN_BIT],
                   drv_en[lvds_cfg_pkg::DRV_TAKEOVER_BIT]}),
        .sync_out(link_cfg)
    );

    assign takeover_l = link_cfg[0];
    assign clk_en_l = link_cfg[1];
    assign lane_en_l = link_cfg[NL+1:2];
    assign rate_l = link_cfg[NL+2];
    assign invert_l = link_cfg[NL+3];
    assign pin_en_l = link_cfg[NL+4];

    // data error events as a toggle
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            err_tog_l <= 1'b0;
        end else if (data_error) begin
            err_tog_l <= ~err_tog_l;
        end
    end

    // lane data and driver enables
    logic [NL-1:0] lane_q;
    logic [NL-1:0] lane_oe_q;

    generate
        for (genvar i = 0; i < NL; i++) begin : g_lane
            always_ff @(posedge link_clk) begin
                if (!link_rst_n) begin
                    lane_q[i] <= 1'b0;
                    lane_oe_q[i] <= 1'b0;
                end else begin
                    lane_q[i] <= lane_data[i];
                    lane_oe_q[i] <= takeover_l ? lane_en_l[i] : pin_en_l;
                end
            end
        end
    endgenerate

    assign data_lane_zero = lane_q[0];
    assign data_lane_one = lane_q[1];
    assign data_lane_two = lane_q[2];
    assign data_lane_three = lane_q[3];
    assign data_lane_four = lane_q[4];
    assign data_lane_zero_oe = lane_oe_q[0];
    assign data_lane_one_oe = lane_oe_q[1];
    assign data_lane_two_oe = lane_oe_q[2];
    assign data_lane_three_oe = lane_oe_q[3];
    assign data_lane_four_oe = lane_oe_q[4];

    // forwarded clock generation
    logic raw_q;
    logic div_q;
    logic next_raw;

    assign next_raw = (rate_l || div_q) ? ~raw_q : raw_q;

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            raw_q <= 1'b0;
            div_q <= 1'b0;
            forwarded_output_clock <= 1'b0;
        end else begin
            raw_q <= next_raw;
            div_q <= ~div_q;
            forwarded_output_clock <= next_raw ^ invert_l;
        end
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            forwarded_output_clock_oe <= 1'b0;
        end else begin
            forwarded_output_clock_oe <= takeover_l ? clk_en_l : pin_en_l;
        end
    end

    // checks in the system domain
    sequence s_write(logic [7:0] addr);
        reg_wr && reg_addr == addr;
    endsequence

    property p_swing;
        @(posedge sys_clk) disable iff (!rst_n)
        s_write(lvds_cfg_pkg::ADDR_DRV_EN) |-> ##2 output_differential_swing == $past(reg_wdata[7], 2);
    endproperty
    a_swing: assert property (p_swing) else $error("swing output does not follow written bit");

    property p_delay;
        @(posedge sys_clk) disable iff (!rst_n)
        s_write(lvds_cfg_pkg::ADDR_TIMING) |-> ##2 fwd_clk_delay_code == $past(reg_wdata[3:2], 2);
    endproperty
    a_delay: assert property (p_delay) else $error("clock delay code does not follow written field");

    property p_select;
        @(posedge sys_clk) disable iff (!rst_n)
        reg_addr == lvds_cfg_pkg::ADDR_EVT_COUNT |=>
            reg_rdata == ($past(evt_cfg[3]) ? $past(8'(data_count)) : $past(8'(cdr_count)));
    endproperty
    a_select: assert property (p_select) else $error("counter readback selects wrong counter");

    sequence s_cdr_event;
        (lock_loss ^ clk_loss) && !evt_cfg[2];
    endsequence

    property p_cdr_inc;
        @(posedge sys_clk) disable iff (!rst_n)
        s_cdr_event |=> cdr_count == $past(cdr_count) + 1'b1;
    endproperty
    a_cdr_inc: assert property (p_cdr_inc) else $error("clock recovery counter missed an event");

    property p_cdr_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        s_write(lvds_cfg_pkg::ADDR_EVT_CFG) ##1 evt_cfg[2] |=> cdr_count == '0;
    endproperty
    a_cdr_clear: assert property (p_cdr_clear) else $error("clock recovery counter not cleared");

    property p_data_clear;
        @(posedge sys_clk) disable iff (!rst_n)
        evt_cfg[1] |=> data_count == '0;
    endproperty
    a_data_clear: assert property (p_data_clear) else $error("data event counter not cleared");

    property p_takeover_reset;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> drv_en == 8'h00 && timing == 8'h28;
    endproperty
    a_takeover_reset: assert property (p_takeover_reset) else $error("register reset values wrong");

    // checks in the link domain
    property p_lane_en;
        @(posedge link_clk) disable iff (!link_rst_n)
        takeover_l |=> lane_oe_q == $past(lane_en_l);
    endproperty
    a_lane_en: assert property (p_lane_en) else $error("lane enables ignore register under takeover");

    property p_clk_en;
        @(posedge link_clk) disable iff (!link_rst_n)
        takeover_l |=> forwarded_output_clock_oe == $past(clk_en_l);
    endproperty
    a_clk_en: assert property (p_clk_en) else $error("clock enable ignores register under takeover");

    property p_default;
        @(posedge link_clk) disable iff (!link_rst_n)
        !takeover_l |=> lane_oe_q == {NL{$past(pin_en_l)}} && forwarded_output_clock_oe == $past(pin_en_l);
    endproperty
    a_default: assert property (p_default) else $error("drivers not pin governed without takeover");

    property p_full_rate;
        @(posedge link_clk) disable iff (!link_rst_n)
        rate_l |=> raw_q != $past(raw_q);
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("full rate clock did not toggle");

    property p_half_rate;
        @(posedge link_clk) disable iff (!link_rst_n)
        !rate_l && !div_q |=> raw_q == $past(raw_q);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("half rate clock toggled early");

    property p_invert;
        @(posedge link_clk) disable iff (!link_rst_n)
        !$past(link_rst_n) == 1'b0 |-> forwarded_output_clock == (raw_q ^ $past(invert_l));
    endproperty
    a_invert: assert property (p_invert) else $error("forwarded clock polarity wrong");
endmodule

// ===== tb/lvds_host_model.sv
// host receiver model: captures driven lanes and counts forwarded clock toggles
`timescale 1ns/1ps
module lvds_host_model (
    // link clock
    input wire logic link_clk,
    // pins from the device
    input wire logic [4:0] lanes,
    input wire logic [4:0] lanes_oe,
    input wire logic fwd_clk,
    input wire logic fwd_clk_oe,
    // what the host saw
    output logic [4:0] lanes_seen,
    output logic [15:0] toggles
);
    logic fwd_clk_last;
    initial begin
        lanes_seen = 5'h00;
        toggles = 16'h0000;
        fwd_clk_last = 1'b0;
    end
    // undriven lanes read as 0 at a terminated receiver
    always @(posedge link_clk) begin
        lanes_seen <= lanes & lanes_oe;
        fwd_clk_last <= fwd_clk;
        if (fwd_clk_oe && fwd_clk !== fwd_clk_last) begin
            toggles <= toggles + 16'h0001;
        end
    end
endmodule

// ===== tb/lvds_output_and_event_config_regs_test.sv
// self-checking bench for the lvds output and event configuration registers
`timescale 1ns/1ps
module lvds_output_and_event_config_regs_test;
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic link_rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_rdata;
    logic pin_en = 1'b0;
    logic recovery_lock = 1'b1;
    logic fwd_present = 1'b1;
    logic [4:0] lane_data = 5'h00;
    logic data_error = 1'b0;
    logic [4:0] lanes;
    logic [4:0] lanes_oe;
    logic fwd_clk;
    logic fwd_clk_oe;
    logic swing;
    logic [1:0] delay_code;
    logic [4:0] lanes_seen;
    logic [15:0] toggles;
    logic [15:0] t0;
    logic [7:0] rd;
    int errors = 0;
    int tests_run = 0;

    always #2.5 sys_clk = ~sys_clk;
    always #3 link_clk = ~link_clk;

    lvds_output_and_event_config_regs i_lvds_output_and_event_config_regs (
        .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .link_rst_n(link_rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
        .pin_drivers_enable(pin_en), .recovery_lock(recovery_lock), .fwd_clk_present(fwd_present),
        .lane_data(lane_data), .data_error(data_error),
        .data_lane_zero(lanes[0]), .data_lane_one(lanes[1]), .data_lane_two(lanes[2]),
        .data_lane_three(lanes[3]), .data_lane_four(lanes[4]),
        .data_lane_zero_oe(lanes_oe[0]), .data_lane_one_oe(lanes_oe[1]), .data_lane_two_oe(lanes_oe[2]),
        .data_lane_three_oe(lanes_oe[3]), .data_lane_four_oe(lanes_oe[4]),
        .forwarded_output_clock(fwd_clk), .forwarded_output_clock_oe(fwd_clk_oe),
        .output_differential_swing(swing), .fwd_clk_delay_code(delay_code)
    );

    lvds_host_model i_lvds_host_model (
        .link_clk(link_clk), .lanes(lanes), .lanes_oe(lanes_oe), .fwd_clk(fwd_clk),
        .fwd_clk_oe(fwd_clk_oe), .lanes_seen(lanes_seen), .toggles(toggles)
    );

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        @(negedge sys_clk);
        reg_addr = a;
        @(negedge sys_clk);
        rd = reg_rdata;
    endtask

    task automatic wait_sys(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic give_verdict();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic test_reset_values();
        rd_reg(8'h27);
        check("drv_en reset", rd, 8'h00);
        rd_reg(8'h28);
        check("timing reset", rd, 8'h28);
        rd_reg(8'h2b);
        check("evt_cfg reset", rd, 8'h00);
        rd_reg(8'h30);
        check("unmapped read", rd, 8'h00);
        check("swing reset", {7'h00, swing}, 8'h00);
        check("delay reset", {6'h00, delay_code}, 8'h02);
    endtask

    task automatic test_swing();
        wr(8'h27, 8'h80);
        wait_sys(3);
        check("swing set", {7'h00, swing}, 8'h01);
        rd_reg(8'h27);
        check("drv_en readback", rd, 8'h80);
        wr(8'h27, 8'h00);
        wait_sys(3);
        check("swing clear", {7'h00, swing}, 8'h00);
    endtask

    task automatic test_enables();
        pin_en = 1'b1;
        wait_sys(10);
        check("pin governs oe", {2'h0, fwd_clk_oe, lanes_oe}, 8'h3f);
        wr(8'h27, 8'h6a);
        wait_sys(10);
        check("takeover oe", {2'h0, fwd_clk_oe, lanes_oe}, 8'h2a);
        pin_en = 1'b0;
        wr(8'h27, 8'h55);
        wait_sys(10);
        check("takeover lanes oe", {2'h0, fwd_clk_oe, lanes_oe}, 8'h15);
        wr(8'h27, 8'h3f);
        wait_sys(10);
        check("no takeover oe", {2'h0, fwd_clk_oe, lanes_oe}, 8'h00);
        wr(8'h27, 8'h5f);
        wait_sys(10);
        @(negedge link_clk);
        lane_data = 5'h16;
        repeat (2) @(negedge link_clk);
        check("lanes seen", {3'h0, lanes_seen}, 8'h16);
    endtask

    task automatic count_toggles(input logic [7:0] exp);
        @(negedge link_clk);
        t0 = toggles;
        repeat (20) @(negedge link_clk);
        check("clock toggles", 8'(toggles - t0), exp);
    endtask

    task automatic link_reset_sample(input logic [7:0] tim, output logic v);
        wr(8'h28, tim);
        wait_sys(4);
        @(negedge link_clk);
        link_rst_n = 1'b0;
        repeat (4) @(negedge link_clk);
        link_rst_n = 1'b1;
        repeat (12) @(negedge link_clk);
        v = fwd_clk;
    endtask

    task automatic test_clock();
        logic pol0;
        logic pol1;
        wr(8'h27, 8'h7f);
        wait_sys(10);
        count_toggles(8'h14);
        wr(8'h28, 8'h08);
        wait_sys(10);
        count_toggles(8'h0a);
        wr(8'h28, 8'hff);
        rd_reg(8'h28);
        check("timing mask", rd, 8'h3c);
        wait_sys(10);
        count_toggles(8'h14);
        for (int d = 0; d < 4; d++) begin
            wr(8'h28, 8'h20 | 8'(d << 2));
            wait_sys(3);
            check("delay code", {6'h00, delay_code}, 8'(d));
        end
        // same phase after a link reset, only the invert bit differs
        link_reset_sample(8'h20, pol0);
        link_reset_sample(8'h30, pol1);
        check("clock polarity", {7'h00, pol1}, {7'h00, ~pol0});
        check("clock oe after reset", {7'h00, fwd_clk_oe}, 8'h01);
    endtask

    task automatic data_pulse();
        @(negedge link_clk);
        data_error = 1'b1;
        @(negedge link_clk);
        data_error = 1'b0;
        repeat (4) @(negedge link_clk);
    endtask

    task automatic test_events();
        recovery_lock = 1'b0;
        wait_sys(6);
        recovery_lock = 1'b1;
        wait_sys(6);
        fwd_present = 1'b0;
        wait_sys(6);
        fwd_present = 1'b1;
        wait_sys(6);
        recovery_lock = 1'b0;
        fwd_present = 1'b0;
        wait_sys(6);
        recovery_lock = 1'b1;
        fwd_present = 1'b1;
        repeat (3) data_pulse();
        wait_sys(8);
        rd_reg(8'h29);
        check("cdr count", rd, 8'h04);
        wr(8'h2b, 8'h08);
        rd_reg(8'h29);
        check("data count", rd, 8'h03);
        wr(8'h2b, 8'h04);
        rd_reg(8'h29);
        check("cdr cleared", rd, 8'h00);
        wr(8'h2b, 8'h08);
        rd_reg(8'h29);
        check("data kept", rd, 8'h03);
        wr(8'h2b, 8'hff);
        rd_reg(8'h2b);
        check("evt_cfg mask", rd, 8'h0e);
        rd_reg(8'h29);
        check("data cleared", rd, 8'h00);
        wr(8'h2b, 8'h00);
        rd_reg(8'h29);
        check("cdr stays zero", rd, 8'h00);
    endtask

    initial begin
        #50000;
        errors++;
        give_verdict();
    end

    initial begin
        wait_sys(10);
        rst_n = 1'b1;
        @(negedge link_clk);
        link_rst_n = 1'b1;
        wait_sys(4);
        test_reset_values();
        test_swing();
        test_enables();
        test_clock();
        test_events();
        give_verdict();
    end
endmodule
